// ### lpr_light_prox_regs.sv
// Function
// - control bits 7:6 scale LED drive: full, half, quarter, one eighth of trim.
// - control bits 5:4 pick prox diode: 01 ch0, 10 ch1, 11 both, 00 reserved.
// - control bits 1:0 pick light gain 1x, 8x, 16x, 120x.
// - fixed read-only 8-bit part code at 0x12; writes ignored.
// - status bit 5 reads 1 while the proximity interrupt is asserted.
// - status bit 4 reads 1 while the light interrupt is asserted.
// - status bit 0 sets once light integration completes with valid results.
// - status register at 0x13 is read-only; bits 7:6 and 3:1 reserved.
// - two 16-bit light results, low then high: 0x14/0x15 and 0x16/0x17.
// - reading a light low byte copies its high byte into a shadow for readback.
// - latched light high byte holds even if new integrations finish meanwhile.
// - proximity result is 16 bits: low byte 0x18, high byte 0x19.
// - proximity low read latches high byte, kept across further conversions.
// - bus lines and interrupt are open-drain, pulled low only, never driven high.
// - light interrupt comes from comparing channel 0 result against thresholds.
`timescale 1ns/1ps
`include "lpr_defs.svh"

module lpr_light_prox_regs #(
   parameter logic [6:0] I2C_ADDR = `LPR_I2C_ADDR_DEFAULT,
   // arbitrary neutral part code
   parameter logic [7:0] PART_ID  = `LPR_PART_ID_DEFAULT
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   output logic             int_out,
   output logic             int_oe,
   input  wire logic [15:0] light_ch0_result,
   input  wire logic [15:0] light_ch1_result,
   input  wire logic        light_cycle_done,
   input  wire logic [15:0] prox_result,
   input  wire logic        prox_cycle_done,
   input  wire logic [15:0] light_thresh_low,
   input  wire logic [15:0] light_thresh_high,
   input  wire logic        prox_irq_active,
   input  wire logic        light_irq_clear,
   input  wire logic        light_valid_clear,
   input  wire logic [7:0]  led_trim_code,
   output logic [1:0]       led_drive_level,
   output logic [7:0]       led_drive_code,
   output logic [1:0]       prox_diode_select,
   output logic             prox_use_ch0,
   output logic             prox_use_ch1,
   output logic             prox_diode_reserved,
   output logic [1:0]       light_gain_select,
   output logic [6:0]       light_gain_factor
);

   localparam int NUM_RESULTS = 3;
   localparam logic [4:0] LOW_ADDR [NUM_RESULTS] = '{`LPR_ADDR_CH0_LOW, `LPR_ADDR_CH1_LOW, `LPR_ADDR_PROX_LOW};

   logic [7:0]          ctrl_r;
   logic [4:0]          ptr_r;
   logic                auto_inc_r;
   logic                light_irq_r;
   logic                light_valid_r;
   logic                int_oe_r;
   logic [7:0]          rd_data_r;
   logic [7:0]          drive_code_r;
   logic                use_ch0_r;
   logic                use_ch1_r;
   logic                diode_rsvd_r;
   lpr_pkg::lpr_gain_t  gain_factor_r;

   logic                wr_valid;
   logic                wr_first;
   logic [7:0]          wr_data;
   logic                rd_req;
   logic                reg_write;
   logic                cmd_write;
   logic                light_out_of_range;
   logic                light_irq_set;
   logic [7:0]          status_byte;
   logic [7:0]          read_mux;

   logic [15:0]         res_in      [NUM_RESULTS];
   logic                res_load    [NUM_RESULTS];
   logic                low_read    [NUM_RESULTS];
   logic [7:0]          low_byte    [NUM_RESULTS];
   logic [7:0]          shadow_high [NUM_RESULTS];

   lpr_i2c_slave #(
      .DEV_ADDR (I2C_ADDR)
   ) u_slave (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .rd_data  (rd_data_r),
      .sda_oe   (sda_oe),
      .wr_valid (wr_valid),
      .wr_first (wr_first),
      .wr_data  (wr_data),
      .rd_req   (rd_req)
   );

   // open-drain: the data level is always low, only the enable moves
   assign sda_out = `LPR_OD_LOW;
   assign scl_out = `LPR_OD_LOW;
   // no clock stretching, the read byte is ready within one cycle
   assign scl_oe  = 1'b0;
   assign int_out = `LPR_OD_LOW;
   assign int_oe  = int_oe_r;

   assign cmd_write = wr_valid & wr_first & wr_data[`LPR_CMD_SELECT_BIT];
   assign reg_write = wr_valid & ~wr_first;

   // command byte sets the pointer and the increment mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ptr_r      <= `LPR_PTR_RESET;
         auto_inc_r <= 1'b0;
      end
      else if (cmd_write)
      begin
         ptr_r      <= wr_data[`LPR_CMD_PTR_MSB:`LPR_CMD_PTR_LSB];
         auto_inc_r <= (wr_data[`LPR_CMD_TYPE_MSB:`LPR_CMD_TYPE_LSB] == `LPR_CMD_TYPE_AUTO_INC);
      end
      else if ((reg_write || rd_req) && auto_inc_r)
         ptr_r <= ptr_r + `LPR_PTR_STEP;
   end

   // only the control register takes writes; identity, status and results ignore them
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ctrl_r <= `LPR_CTRL_RESET;
      else if (reg_write && ptr_r == `LPR_ADDR_CONTROL)
         ctrl_r <= wr_data & `LPR_CTRL_WR_MASK;
   end

   assign led_drive_level   = ctrl_r[`LPR_CTRL_DRIVE_MSB:`LPR_CTRL_DRIVE_LSB];
   assign prox_diode_select = ctrl_r[`LPR_CTRL_DIODE_MSB:`LPR_CTRL_DIODE_LSB];
   assign light_gain_select = ctrl_r[`LPR_CTRL_GAIN_MSB:`LPR_CTRL_GAIN_LSB];

   // decoded analog settings follow the control register by one cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         drive_code_r <= `LPR_BYTE_RESET;
      else
         drive_code_r <= led_trim_code >> led_drive_level;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         use_ch0_r    <= 1'b0;
         use_ch1_r    <= 1'b0;
         diode_rsvd_r <= 1'b1;
      end
      else
      begin
         use_ch0_r    <= (prox_diode_select == `LPR_DIODE_CH0) || (prox_diode_select == `LPR_DIODE_BOTH);
         use_ch1_r    <= (prox_diode_select == `LPR_DIODE_CH1) || (prox_diode_select == `LPR_DIODE_BOTH);
         diode_rsvd_r <= (prox_diode_select == `LPR_DIODE_RESERVED);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         gain_factor_r <= `LPR_GAIN_1X;
      else
      begin
         unique case (light_gain_select)
            `LPR_GAIN_SEL_1X:   gain_factor_r <= `LPR_GAIN_1X;
            `LPR_GAIN_SEL_8X:   gain_factor_r <= `LPR_GAIN_8X;
            `LPR_GAIN_SEL_16X:  gain_factor_r <= `LPR_GAIN_16X;
            `LPR_GAIN_SEL_120X: gain_factor_r <= `LPR_GAIN_120X;
         endcase
      end
   end

   assign led_drive_code      = drive_code_r;
   assign prox_use_ch0        = use_ch0_r;
   assign prox_use_ch1        = use_ch1_r;
   assign prox_diode_reserved = diode_rsvd_r;
   assign light_gain_factor   = gain_factor_r;

   // light interrupt judged on channel 0 only, at each completed integration
   assign light_out_of_range = (light_ch0_result < light_thresh_low) || (light_ch0_result > light_thresh_high);
   assign light_irq_set      = light_cycle_done & light_out_of_range;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         light_irq_r <= 1'b0;
      else if (light_irq_set)
         light_irq_r <= 1'b1;
      else if (light_irq_clear)
         light_irq_r <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         light_valid_r <= 1'b0;
      else if (light_cycle_done)
         light_valid_r <= 1'b1;
      else if (light_valid_clear)
         light_valid_r <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         int_oe_r <= 1'b0;
      else
         int_oe_r <= prox_irq_active | light_irq_r;
   end

   always_comb
   begin
      status_byte = `LPR_STAT_RESET;
      status_byte[`LPR_STAT_PROX_IRQ_BIT]  = prox_irq_active;
      status_byte[`LPR_STAT_LIGHT_IRQ_BIT] = light_irq_r;
      status_byte[`LPR_STAT_VALID_BIT]     = light_valid_r;
   end

   assign res_in[0]   = light_ch0_result;
   assign res_in[1]   = light_ch1_result;
   assign res_in[2]   = prox_result;
   assign res_load[0] = light_cycle_done;
   assign res_load[1] = light_cycle_done;
   assign res_load[2] = prox_cycle_done;

   // one shadow per result so reading one channel never disturbs another
   genvar gi;
   generate
      for (gi = 0; gi < NUM_RESULTS; gi++)
      begin : g_result
         assign low_read[gi] = rd_req & (ptr_r == LOW_ADDR[gi]);

         lpr_result_latch #(
            .RESULT_W (16)
         ) u_latch (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .result_in   (res_in[gi]),
            .result_load (res_load[gi]),
            .low_read    (low_read[gi]),
            .low_byte    (low_byte[gi]),
            .shadow_high (shadow_high[gi])
         );
      end
   endgenerate

   always_comb
   begin
      unique case (ptr_r)
         `LPR_ADDR_CONTROL:   read_mux = ctrl_r;
         `LPR_ADDR_PART_ID:   read_mux = PART_ID;
         `LPR_ADDR_STATUS:    read_mux = status_byte;
         `LPR_ADDR_CH0_LOW:   read_mux = low_byte[0];
         `LPR_ADDR_CH0_HIGH:  read_mux = shadow_high[0];
         `LPR_ADDR_CH1_LOW:   read_mux = low_byte[1];
         `LPR_ADDR_CH1_HIGH:  read_mux = shadow_high[1];
         `LPR_ADDR_PROX_LOW:  read_mux = low_byte[2];
         `LPR_ADDR_PROX_HIGH: read_mux = shadow_high[2];
         default:             read_mux = `LPR_READ_UNMAPPED;
      endcase
   end

   // prefetch happens only once the byte is sure to be sent
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rd_data_r <= `LPR_BYTE_RESET;
      else if (rd_req)
         rd_data_r <= read_mux;
   end

endmodule : lpr_light_prox_regs

// ### lpr_defs.svh
`ifndef LPR_DEFS_SVH
`define LPR_DEFS_SVH

// register pointer values
`define LPR_ADDR_CONTROL      5'h0F
`define LPR_ADDR_PART_ID      5'h12
`define LPR_ADDR_STATUS       5'h13
`define LPR_ADDR_CH0_LOW      5'h14
`define LPR_ADDR_CH0_HIGH     5'h15
`define LPR_ADDR_CH1_LOW      5'h16
`define LPR_ADDR_CH1_HIGH     5'h17
`define LPR_ADDR_PROX_LOW     5'h18
`define LPR_ADDR_PROX_HIGH    5'h19
`define LPR_PTR_STEP          5'h01
`define LPR_PTR_RESET         5'h00

// analog control fields
`define LPR_CTRL_RESET        8'h00
`define LPR_CTRL_WR_MASK      8'hF3
`define LPR_CTRL_DRIVE_MSB    7
`define LPR_CTRL_DRIVE_LSB    6
`define LPR_CTRL_DIODE_MSB    5
`define LPR_CTRL_DIODE_LSB    4
`define LPR_CTRL_GAIN_MSB     1
`define LPR_CTRL_GAIN_LSB     0

// diode select codes
`define LPR_DIODE_RESERVED    2'h0
`define LPR_DIODE_CH0         2'h1
`define LPR_DIODE_CH1         2'h2
`define LPR_DIODE_BOTH        2'h3

// gain select codes and factors
`define LPR_GAIN_SEL_1X       2'h0
`define LPR_GAIN_SEL_8X       2'h1
`define LPR_GAIN_SEL_16X      2'h2
`define LPR_GAIN_SEL_120X     2'h3
`define LPR_GAIN_1X           7'h01
`define LPR_GAIN_8X           7'h08
`define LPR_GAIN_16X          7'h10
`define LPR_GAIN_120X         7'h78

// device status bit positions
`define LPR_STAT_PROX_IRQ_BIT  5
`define LPR_STAT_LIGHT_IRQ_BIT 4
`define LPR_STAT_VALID_BIT     0
`define LPR_STAT_RESET         8'h00

// command byte fields
`define LPR_CMD_SELECT_BIT    7
`define LPR_CMD_TYPE_MSB      6
`define LPR_CMD_TYPE_LSB      5
`define LPR_CMD_PTR_MSB       4
`define LPR_CMD_PTR_LSB       0
`define LPR_CMD_TYPE_AUTO_INC 2'h1

// bus and identity
`define LPR_I2C_ADDR_DEFAULT  7'h39
`define LPR_PART_ID_DEFAULT   8'h5A
`define LPR_READ_UNMAPPED     8'h00
`define LPR_BYTE_BITS         4'h8
`define LPR_BIT_CNT_RESET     4'h0
`define LPR_BYTE_RESET        8'h00
`define LPR_RESULT_RESET      16'h0000
`define LPR_OD_LOW            1'b0

`endif

// ### lpr_pkg.sv
package lpr_pkg;

   typedef enum logic [2:0]
   {
      st_idle     = 3'h0,
      st_addr     = 3'h1,
      st_addr_ack = 3'h2,
      st_write    = 3'h3,
      st_wr_ack   = 3'h4,
      st_read     = 3'h5,
      st_rd_ack   = 3'h6
   } lpr_i2c_state_t;

   typedef logic [6:0] lpr_gain_t;

endpackage : lpr_pkg

// ### lpr_i2c_slave.sv
`timescale 1ns/1ps
`include "lpr_defs.svh"

module lpr_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = `LPR_I2C_ADDR_DEFAULT
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [7:0] rd_data,
   output logic            sda_oe,
   output logic            wr_valid,
   output logic            wr_first,
   output logic [7:0]      wr_data,
   output logic            rd_req
);

   lpr_pkg::lpr_i2c_state_t state_r;
   logic       scl_q_r;
   logic       sda_q_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shreg_r;
   logic [7:0] tx_r;
   logic       rw_r;
   logic       first_r;
   logic       mack_r;
   logic       sda_low_r;
   logic       wr_valid_r;
   logic       wr_first_r;
   logic       rd_req_r;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // lines idle high, so reset to high avoids a false edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_in;
         sda_q_r <= sda_in;
      end
   end

   assign scl_rise  = scl_in & ~scl_q_r;
   assign scl_fall  = ~scl_in & scl_q_r;
   assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
   assign stop_det  = scl_in & scl_q_r & ~sda_q_r & sda_in;

   // rd_req fires on a rising scl; rd_data must be ready before the next falling scl
   always_ff @(posedge ref_clk)
   begin
      wr_valid_r <= 1'b0;
      rd_req_r   <= 1'b0;
      if (rst)
      begin
         state_r    <= lpr_pkg::st_idle;
         bit_cnt_r  <= `LPR_BIT_CNT_RESET;
         shreg_r    <= `LPR_BYTE_RESET;
         tx_r       <= `LPR_BYTE_RESET;
         rw_r       <= 1'b0;
         first_r    <= 1'b0;
         mack_r     <= 1'b0;
         sda_low_r  <= 1'b0;
         wr_first_r <= 1'b0;
      end
      else if (stop_det)
      begin
         state_r   <= lpr_pkg::st_idle;
         sda_low_r <= 1'b0;
      end
      else if (start_det)
      begin
         state_r   <= lpr_pkg::st_addr;
         bit_cnt_r <= `LPR_BIT_CNT_RESET;
         first_r   <= 1'b1;
         sda_low_r <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            lpr_pkg::st_idle:
            begin
            end
            lpr_pkg::st_addr:
            begin
               if (scl_rise)
               begin
                  shreg_r   <= {shreg_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               else if (scl_fall && bit_cnt_r == `LPR_BYTE_BITS)
               begin
                  if (shreg_r[7:1] == DEV_ADDR)
                  begin
                     rw_r      <= shreg_r[0];
                     state_r   <= lpr_pkg::st_addr_ack;
                     sda_low_r <= 1'b1;
                  end
                  else
                     state_r <= lpr_pkg::st_idle;
               end
            end
            lpr_pkg::st_addr_ack:
            begin
               if (scl_rise && rw_r)
                  rd_req_r <= 1'b1;
               else if (scl_fall)
               begin
                  bit_cnt_r <= `LPR_BIT_CNT_RESET;
                  if (rw_r)
                  begin
                     state_r   <= lpr_pkg::st_read;
                     tx_r      <= rd_data;
                     sda_low_r <= ~rd_data[7];
                  end
                  else
                  begin
                     state_r   <= lpr_pkg::st_write;
                     sda_low_r <= 1'b0;
                  end
               end
            end
            lpr_pkg::st_write:
            begin
               if (scl_rise)
               begin
                  shreg_r   <= {shreg_r[6:0], sda_in};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               else if (scl_fall && bit_cnt_r == `LPR_BYTE_BITS)
               begin
                  wr_valid_r <= 1'b1;
                  wr_first_r <= first_r;
                  first_r    <= 1'b0;
                  state_r    <= lpr_pkg::st_wr_ack;
                  sda_low_r  <= 1'b1;
               end
            end
            lpr_pkg::st_wr_ack:
            begin
               if (scl_fall)
               begin
                  state_r   <= lpr_pkg::st_write;
                  bit_cnt_r <= `LPR_BIT_CNT_RESET;
                  sda_low_r <= 1'b0;
               end
            end
            lpr_pkg::st_read:
            begin
               if (scl_rise)
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               else if (scl_fall)
               begin
                  if (bit_cnt_r == `LPR_BYTE_BITS)
                  begin
                     state_r   <= lpr_pkg::st_rd_ack;
                     sda_low_r <= 1'b0;
                  end
                  else
                  begin
                     tx_r      <= {tx_r[6:0], 1'b0};
                     sda_low_r <= ~tx_r[6];
                  end
               end
            end
            lpr_pkg::st_rd_ack:
            begin
               if (scl_rise)
               begin
                  mack_r   <= ~sda_in;
                  rd_req_r <= ~sda_in;
               end
               else if (scl_fall)
               begin
                  if (mack_r)
                  begin
                     state_r   <= lpr_pkg::st_read;
                     bit_cnt_r <= `LPR_BIT_CNT_RESET;
                     tx_r      <= rd_data;
                     sda_low_r <= ~rd_data[7];
                  end
                  else
                     state_r <= lpr_pkg::st_idle;
               end
            end
            default:
               state_r <= lpr_pkg::st_idle;
         endcase
      end
   end

   assign sda_oe   = sda_low_r;
   assign wr_valid = wr_valid_r;
   assign wr_first = wr_first_r;
   assign wr_data  = shreg_r;
   assign rd_req   = rd_req_r;

endmodule : lpr_i2c_slave

// ### lpr_result_latch.sv
`timescale 1ns/1ps
`include "lpr_defs.svh"

module lpr_result_latch #(
   parameter int RESULT_W = 16
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic [RESULT_W-1:0] result_in,
   input  wire logic                result_load,
   input  wire logic                low_read,
   output logic [7:0]               low_byte,
   output logic [7:0]               shadow_high
);

   logic [RESULT_W-1:0] result_r;
   logic [7:0]          shadow_r;

   generate
      if (RESULT_W != 16)
      begin : g_bad_width
         $error("lpr_result_latch supports only a 16-bit result");
      end
   endgenerate

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         result_r <= `LPR_RESULT_RESET;
      else if (result_load)
         result_r <= result_in;
   end

   // a load in the same cycle as the low read still pairs old low with old high
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         shadow_r <= `LPR_BYTE_RESET;
      else if (low_read)
         shadow_r <= result_r[15:8];
   end

   assign low_byte    = result_r[7:0];
   assign shadow_high = shadow_r;

endmodule : lpr_result_latch

// ### lpr_light_prox_regs_asserts.sv
`timescale 1ns/1ps
module lpr_light_prox_regs_asserts (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       int_out,
   input wire logic       int_oe,
   input wire logic       prox_irq_active,
   input wire logic [7:0] led_trim_code,
   input wire logic [1:0] led_drive_level,
   input wire logic [7:0] led_drive_code,
   input wire logic [1:0] prox_diode_select,
   input wire logic       prox_use_ch0,
   input wire logic       prox_use_ch1,
   input wire logic       prox_diode_reserved,
   input wire logic [1:0] light_gain_select,
   input wire logic [6:0] light_gain_factor
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   scl_free_a: assert property (!scl_oe && !scl_out) else $error("scl driven");
   sda_low_a: assert property (!sda_out) else $error("sda driven high");
   int_low_a: assert property (!int_out) else $error("irq driven high");
   drive_code_a: assert property (!$past(rst) |->
      led_drive_code == ($past(led_trim_code) >> $past(led_drive_level))) else $error("drive code wrong");
   gain_factor_a: assert property (!$past(rst) |-> light_gain_factor ==
      ($past(light_gain_select) == 2'h3 ? 7'h78 :
      7'h01 << ($past(light_gain_select) == 2'h0 ? 0 : $past(light_gain_select) + 2))) else $error("gain wrong");
   diode_dec_a: assert property (!$past(rst) |-> {prox_use_ch1, prox_use_ch0} == $past(prox_diode_select)
      && prox_diode_reserved == ($past(prox_diode_select) == 2'h0)) else $error("diode decode wrong");
   prox_pin_a: assert property ($past(prox_irq_active) && !$past(rst) |-> int_oe) else $error("irq pin idle");
   ctrl_edge_a: assert property (!$past(rst) && $changed({led_drive_level, prox_diode_select})
      |-> !scl_in) else $error("control moved outside a write");
   ack_edge_a: assert property (!$past(rst) && $changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
endmodule : lpr_light_prox_regs_asserts
bind lpr_light_prox_regs lpr_light_prox_regs_asserts chk_u (.*);

// ### lpr_host_model.sv
`timescale 1ns/1ps
module lpr_host_model (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_pull
);
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // every change waits 4 cycles, so scl low and high phases last at least 4 cycles
   task automatic step(input logic c, input logic p);
      repeat (4) @(posedge ref_clk);
      scl <= c;
      sda_pull <= p; // pull low only, never drive high
   endtask : step
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, !b);
      step(1'b1, !b);
      @(negedge ref_clk) r = sda_line;
      step(1'b0, !b);
   endtask : bit_io
   task automatic byte_io(input logic [7:0] b, input logic m, output logic [7:0] r, output logic s);
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
      bit_io(m, s);
   endtask : byte_io
   task automatic xfer(input logic [6:0] a, input logic [7:0] c, input logic rd, input logic [7:0] d,
                       input int n, output logic [15:0] v, output logic ok);
      logic [7:0] r;
      logic       s;
      v = 16'h0000;
      step(scl, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      byte_io({a, 1'b0}, 1'b1, r, s);
      ok = !s;
      byte_io(c, 1'b1, r, s);
      if (rd)
      begin
         step(1'b0, 1'b0);
         step(1'b1, 1'b0);
         step(1'b1, 1'b1);
         step(1'b0, 1'b1);
         byte_io({a, 1'b1}, 1'b1, r, s);
         for (int k = 0; k < n; k++)
         begin
            byte_io(8'hFF, k == n - 1, r, s); // low byte first, last byte not acked
            v[8 * k +: 8] = r;
         end
      end
      else
         byte_io(d & 8'hF3, 1'b1, r, s); // reserved control bits sent as zero
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b1, 1'b0);
   endtask : xfer
endmodule : lpr_host_model

// ### lpr_light_prox_regs_tb.sv
`timescale 1ns/1ps
module lpr_light_prox_regs_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        scl_h;
   logic        sda_pull;
   logic        scl_oe;
   logic        sda_oe;
   logic        lcd = 1'b0;
   logic        pcd = 1'b0;
   logic        pia = 1'b0;
   logic        lic = 1'b0;
   logic        lvc = 1'b0;
   logic [15:0] ch0 = 16'h0000;
   logic [15:0] ch1 = 16'h0000;
   logic [15:0] prx = 16'h0000;
   logic [7:0]  trim = 8'hC8;
   logic [7:0]  dcode;
   logic        u0;
   logic        u1;
   logic        ures;
   logic [6:0]  gfac;
   int          errors = 0;
   int          check_count = 0;
   int          cyc = 0;
   wire         scl_line = scl_h & !scl_oe;
   wire         sda_line = !(sda_pull | sda_oe);
   // arbitrary part code
   lpr_light_prox_regs #(.PART_ID(8'hA7)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .int_out(), .int_oe(),
      .light_ch0_result(ch0), .light_ch1_result(ch1), .light_cycle_done(lcd), .prox_result(prx),
      .prox_cycle_done(pcd), .light_thresh_low(16'h0010), .light_thresh_high(16'h1000),
      .prox_irq_active(pia), .light_irq_clear(lic), .light_valid_clear(lvc), .led_trim_code(trim),
      .led_drive_level(), .led_drive_code(dcode), .prox_diode_select(), .prox_use_ch0(u0),
      .prox_use_ch1(u1), .prox_diode_reserved(ures), .light_gain_select(), .light_gain_factor(gfac)
   );
   lpr_host_model host_u (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl_h), .sda_pull(sda_pull));
   initial forever #10 ref_clk = ~ref_clk;
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic rd(input logic [4:0] p, input int n, output logic [15:0] v);
      logic ok;
      host_u.xfer(7'h39, {3'h5, p}, 1'b1, 8'h00, n, v, ok);
   endtask : rd
   task automatic wr(input logic [4:0] p, input logic [7:0] d);
      logic [15:0] v;
      logic        ok;
      host_u.xfer(7'h39, {3'h5, p}, 1'b0, d, 1, v, ok);
      cmp(ok, 1'b1);
   endtask : wr
   task automatic load(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      @(posedge ref_clk);
      ch0 <= a;
      ch1 <= b;
      prx <= c;
      lcd <= 1'b1;
      pcd <= 1'b1;
      @(posedge ref_clk);
      lcd <= 1'b0;
      pcd <= 1'b0;
   endtask : load
   task automatic t_ctrl;
      logic [15:0] v;
      logic [6:0]  g[4];
      g = '{7'h01, 7'h08, 7'h10, 7'h78};
      for (int i = 0; i < 4; i++)
      begin
         wr(5'h0F, {i[1:0], i[1:0], 2'h3, i[1:0]});
         @(negedge ref_clk);
         cmp(dcode, trim >> i);
         cmp({u1, u0, ures}, {i[1:0], i == 0});
         cmp(gfac, g[i]);
         rd(5'h0F, 1, v);
         cmp(v, {i[1:0], i[1:0], 2'h0, i[1:0]});
      end
   endtask : t_ctrl
   task automatic t_id;
      logic [15:0] v;
      logic        ok;
      wr(5'h12, 8'h00);
      host_u.xfer(7'h39, 8'h92, 1'b1, 8'h00, 2, v, ok); // pointer held without auto-increment
      cmp(v, 16'hA7A7);
      rd(5'h1C, 1, v);
      cmp(v, 16'h0000);
   endtask : t_id
   task automatic t_status;
      logic [15:0] v;
      @(posedge ref_clk);
      pia <= 1'b1;
      load(16'h1234, 16'hABCD, 16'h5678);
      rd(5'h13, 1, v);
      cmp(v, 16'h0031);
      @(posedge ref_clk);
      pia <= 1'b0;
      lic <= 1'b1;
      lvc <= 1'b1;
      @(posedge ref_clk);
      lic <= 1'b0;
      lvc <= 1'b0;
      rd(5'h13, 1, v);
      cmp(v, 16'h0000);
      load(16'h0800, 16'hABCD, 16'h5678);
      rd(5'h13, 1, v);
      cmp(v, 16'h0001);
   endtask : t_status
   task automatic t_pair;
      logic [15:0] v;
      logic [15:0] x[3];
      x = '{16'h1234, 16'hABCD, 16'h5678};
      load(x[0], x[1], x[2]);
      for (int k = 0; k < 3; k++)
      begin
         fork
            rd(5'h14 + 5'(2 * k), 2, v);
            begin
               // lands between the low and high byte fetches
               repeat (400) @(posedge ref_clk);
               load(~x[0], ~x[1], ~x[2]);
            end
         join
         cmp(v, x[k]);
         load(x[0], x[1], x[2]);
      end
      rd(5'h18, 2, v);
      cmp(16'((17'(v) + 17'(x[2])) >> 1), x[2]);
      load(~x[0], ~x[1], ~x[2]);
      rd(5'h15, 1, v);
      cmp(v, 16'h0012);
   endtask : t_pair
   task automatic t_nak;
      logic [15:0] v;
      logic        ok;
      host_u.xfer(7'h2A, 8'hB3, 1'b1, 8'h00, 1, v, ok);
      cmp({ok, v[7:0]}, 9'h0FF);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(5'h0F, 1, v);
      cmp(v, 16'h0000);
   endtask : t_nak
   task report_and_stop;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         errors++;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_ctrl;
      t_id;
      t_status;
      t_pair;
      t_nak;
      report_and_stop;
   end
endmodule : lpr_light_prox_regs_tb
